// *** rtl/oec_consts.vh ***
// Constants for the operand and system-bus event counter block.
// Assumes inclusion by bare name from the rtl/ files of this block.
`ifndef OEC_CONSTS_VH
`define OEC_CONSTS_VH

// Register word indices, taken from paddr[5:2].
`define OEC_IDX_SEL0     4'h0
`define OEC_IDX_SEL3     4'h3
`define OEC_IDX_CNT0     4'h4
`define OEC_IDX_CNT3     4'h7
`define OEC_IDX_CTRL     4'h8
`define OEC_IDX_STAT     4'h9

// Control register fields.
`define OEC_CTRL_RUN     0
`define OEC_CTRL_CLR     1

// Reset values.
`define OEC_SEL_RST      4'h0
`define OEC_CTRL_RST     2'h0

// Event select codes.
`define OEC_EV_NONE      4'h0
`define OEC_EV_LRAM_RD   4'h1
`define OEC_EV_LRAM_WR   4'h2
`define OEC_EV_ILM_OP    4'h3
`define OEC_EV_OC_RMISS  4'h4
`define OEC_EV_OC_WMISS  4'h5
`define OEC_EV_OP_RWAIT  4'h6
`define OEC_EV_OP_WWAIT  4'h7
`define OEC_EV_RMISS_W   4'h8
`define OEC_EV_WMISS_W   4'h9
`define OEC_EV_ILM_RWAIT 4'ha
`define OEC_EV_ILM_WWAIT 4'hb
`define OEC_EV_SB_REQ    4'hc
`define OEC_EV_SB_RSP    4'hd
`define OEC_EV_SB_REQW   4'he
`define OEC_EV_SB_RSPW   4'hf

// First channel index that may select system-bus events.
`define OEC_SB_FIRST_CH  2

`endif

// *** rtl/oec_sync.v ***
// Two-flop synchroniser for a vector of slow levels.
// Assumes each bit is an independent level; no bus coherence is given.
`timescale 1ns/100ps
module oec_sync #(
  parameter W = 1
) (
  // Clock and reset.
  input  wire         clk_sys,
  input  wire         reset_n,
  // Data.
  input  wire [W-1:0] d_in,
  output wire [W-1:0] d_out
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // The first flop feeds only the second one.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end

  assign d_out = sync_reg;
endmodule

// *** rtl/oec_chan.v ***
// One measurement counter channel.
// Assumes the per-event increments arrive packed two bits per event code.
`timescale 1ns/100ps
module oec_chan #(
  parameter CNT_W = 32
) (
  // Clock and reset.
  input  wire             clk_sys,
  input  wire             reset_n,
  // Control.
  input  wire             run,
  input  wire             clear,
  input  wire [3:0]       sel,
  input  wire             load,
  input  wire [CNT_W-1:0] load_data,
  // Event increments, two bits for each select code.
  input  wire [31:0]      evt_inc,
  // Result.
  output wire [CNT_W-1:0] count,
  output wire             ovf
);
  reg  [CNT_W-1:0] count_reg;
  reg  [CNT_W-1:0] count_next;
  reg              ovf_reg;
  reg              ovf_next;
  reg  [1:0]       inc;
  reg  [CNT_W:0]   sum;

  // At most two steps per clock, held otherwise; clear wins, then software load.
  always @* begin
    inc        = evt_inc[sel*2 +: 2];
    sum        = {1'b0, count_reg} + {{(CNT_W-1){1'b0}}, inc};
    count_next = count_reg;
    ovf_next   = 1'b0;
    if (clear) begin
      count_next = {CNT_W{1'b0}};
    end else if (load) begin
      count_next = load_data;
    end else if (run) begin
      count_next = sum[CNT_W-1:0];
      ovf_next   = sum[CNT_W];
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= {CNT_W{1'b0}};
      ovf_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      ovf_reg   <= ovf_next;
    end
  end

  assign count = count_reg;
  assign ovf   = ovf_reg;
endmodule

// *** rtl/oec_top.v ***
// Operand and system-bus event qualification with four counter channels.
// Assumes CPU-side event strobes are on clk_sys; system-bus signals and
// the system bus clock come from another domain and are synchronised here.
`timescale 1ns/100ps
`include "oec_consts.vh"

module oec_top #(
  parameter CNT_W = 32,
  parameter NREQ  = 4
) (
  // Clock and reset.
  input  wire             clk_sys,
  input  wire             reset_n,
  // APB slave.
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [7:0]       paddr,
  input  wire [31:0]      pwdata,
  output wire [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  // XY bus moves into the dual data RAM.
  input  wire             xy_x_valid,
  input  wire             xy_x_write,
  input  wire             xy_y_valid,
  input  wire             xy_y_write,
  // Operand bus accesses.
  input  wire             op_rd_valid,
  input  wire             op_wr_valid,
  input  wire             op_lram_hit,
  input  wire             op_ilm_hit,
  input  wire             op_prefetch,
  // Operand cache.
  input  wire             oc_rd_miss,
  input  wire             oc_wr_miss,
  input  wire             oc_wr_through,
  // Operand wait cycles.
  input  wire             op_rd_wait,
  input  wire             op_wr_wait,
  input  wire             rd_miss_wait,
  input  wire             fill_wait,
  input  wire             wr_miss_wait,
  input  wire             ilm_rd_wait,
  input  wire             ilm_wr_wait,
  // System bus, foreign clock domain.
  input  wire             sb_clk,
  input  wire             sb_req_cell,
  input  wire             sb_rsp_cell,
  input  wire [NREQ-1:0]  sb_req,
  input  wire [NREQ-1:0]  sb_gnt,
  input  wire [NREQ-1:0]  sb_r_req,
  input  wire [NREQ-1:0]  sb_r_gnt
);
  localparam SBW = 3 + 4 * NREQ;

  // True for the four system-bus select codes.
  function is_sb_code;
    input [3:0] code;
    begin
      is_sb_code = (code >= `OEC_EV_SB_REQ);
    end
  endfunction

  // Widens a one-bit event to a two-bit increment.
  function [1:0] one;
    input b;
    begin
      one = {1'b0, b};
    end
  endfunction

  // Synchronised system-bus signals.
  wire [SBW-1:0]  sb_s;
  wire            s_clk;
  wire            s_req_cell;
  wire            s_rsp_cell;
  wire [NREQ-1:0] s_req;
  wire [NREQ-1:0] s_gnt;
  wire [NREQ-1:0] s_r_req;
  wire [NREQ-1:0] s_r_gnt;
  reg             s_clk_d_reg;
  wire            sb_tick;

  // Registers.
  reg [3:0]       sel_reg [0:3];
  reg [1:0]       ctrl_reg;
  reg [3:0]       stat_reg;
  reg             pready_reg;
  reg             pslverr_reg;
  reg [31:0]      prdata_reg;
  reg [31:0]      rdata;
  reg             addr_ok;
  reg             sel_bad;

  wire            acc      = psel & penable & ~pready_reg;
  wire            commit   = psel & penable & pready_reg;
  wire [3:0]      idx      = paddr[5:2];
  wire [1:0]      ch_idx   = idx[1:0];
  wire            wr_sel   = (idx <= `OEC_IDX_SEL3);
  wire            wr_cnt   = (idx >= `OEC_IDX_CNT0) && (idx <= `OEC_IDX_CNT3);
  wire [3:0]      ovf;
  wire [CNT_W-1:0] cnt [0:3];

  // Events.
  wire            xy_dual;
  wire            xy_rd;
  wire            xy_wr;
  wire            op_lram_rd;
  wire            op_lram_wr;
  wire            ilm_access;
  wire            oc_rmiss_q;
  wire            oc_wmiss_q;
  wire            rmiss_wait_any;
  wire            sb_req_wait;
  wire            sb_rsp_wait;
  wire            sb_req_ev;
  wire            sb_rsp_ev;
  wire            sb_req_w_ev;
  wire            sb_rsp_w_ev;
  wire [31:0]     evt_inc;

  oec_sync #(
    .W (SBW)
  ) u_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .d_in    ({sb_clk, sb_req_cell, sb_rsp_cell, sb_req, sb_gnt, sb_r_req, sb_r_gnt}),
    .d_out   (sb_s)
  );

  assign {s_clk, s_req_cell, s_rsp_cell, s_req, s_gnt, s_r_req, s_r_gnt} = sb_s;

  // A rising edge of the synchronised bus clock marks one bus cycle.
  // The bus clock must run well below half of clk_sys for this to work.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_clk_d_reg <= 1'b0;
    end else begin
      s_clk_d_reg <= s_clk;
    end
  end

  assign sb_tick = s_clk & ~s_clk_d_reg;

  // Paired X and Y moves give a single count in either direction.
  assign xy_dual = xy_x_valid & xy_y_valid;
  assign xy_rd   = xy_dual | (xy_x_valid & ~xy_x_write) | (xy_y_valid & ~xy_y_write);
  assign xy_wr   = xy_dual | (xy_x_valid & xy_x_write) | (xy_y_valid & xy_y_write);

  // Operand bus hits in the dual data RAM or the operand local memory.
  // The XY part is added separately, so both buses count in one cycle.
  assign op_lram_rd = op_rd_valid & op_lram_hit;
  assign op_lram_wr = op_wr_valid & op_lram_hit;
  assign ilm_access = (op_rd_valid | op_wr_valid) & op_ilm_hit;

  // Cache misses that leave the core. Prefetch misses are dropped, and a
  // write-through store is not a write miss even when the line is absent.
  assign oc_rmiss_q = oc_rd_miss & ~op_prefetch;
  assign oc_wmiss_q = oc_wr_miss & ~oc_wr_through & ~op_prefetch;

  // Fill waits caused by contention are part of the read miss wait.
  assign rmiss_wait_any = rd_miss_wait | fill_wait;

  // Any request still without its grant makes the whole bus cycle a wait
  // cycle; the OR folds many waiting requests into a single count.
  assign sb_req_wait = |(s_req & ~s_gnt);
  assign sb_rsp_wait = |(s_r_req & ~s_r_gnt);

  // Bus events count once per bus cycle, at the synchronised clock edge.
  assign sb_req_ev   = sb_tick & s_req_cell;
  assign sb_rsp_ev   = sb_tick & s_rsp_cell;
  assign sb_req_w_ev = sb_tick & sb_req_wait;
  assign sb_rsp_w_ev = sb_tick & sb_rsp_wait;

  // Per-code increments; the local RAM events may add two per clock when
  // the XY bus and the operand bus both hit in the same cycle.
  assign evt_inc[1:0]   = 2'h0;
  assign evt_inc[3:2]   = one(xy_rd) + one(op_lram_rd);
  assign evt_inc[5:4]   = one(xy_wr) + one(op_lram_wr);
  assign evt_inc[7:6]   = one(ilm_access);
  assign evt_inc[9:8]   = one(oc_rmiss_q);
  assign evt_inc[11:10] = one(oc_wmiss_q);
  assign evt_inc[13:12] = one(op_rd_wait);
  assign evt_inc[15:14] = one(op_wr_wait);
  assign evt_inc[17:16] = one(rmiss_wait_any);
  assign evt_inc[19:18] = one(wr_miss_wait);
  assign evt_inc[21:20] = one(ilm_rd_wait);
  assign evt_inc[23:22] = one(ilm_wr_wait);
  assign evt_inc[25:24] = one(sb_req_ev);
  assign evt_inc[27:26] = one(sb_rsp_ev);
  assign evt_inc[29:28] = one(sb_req_w_ev);
  assign evt_inc[31:30] = one(sb_rsp_w_ev);

  // Address decode and read mux, used when the answer is prepared.
  always @* begin
    addr_ok = wr_sel | wr_cnt | (idx == `OEC_IDX_CTRL) | (idx == `OEC_IDX_STAT);
    sel_bad = wr_sel & pwrite & (ch_idx < `OEC_SB_FIRST_CH) & is_sb_code(pwdata[3:0]);
    rdata   = 32'h0000_0000;
    if (wr_sel) begin
      rdata[3:0] = sel_reg[ch_idx];
    end else if (wr_cnt) begin
      rdata[CNT_W-1:0] = cnt[ch_idx];
    end else if (idx == `OEC_IDX_CTRL) begin
      rdata[1:0] = ctrl_reg;
    end else if (idx == `OEC_IDX_STAT) begin
      rdata[3:0] = stat_reg;
    end
  end

  // One wait state: pready rises on the second access cycle. Unmapped
  // addresses and illegal selections answer with pslverr.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= acc;
      pslverr_reg <= acc & (~addr_ok | sel_bad);
      // Read data stands for the answer cycle only and is zero otherwise.
      if (acc && !pwrite && addr_ok) begin
        prdata_reg <= rdata;
      end else begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  // Select and control registers; clear is a one-cycle self-clearing bit.
  // A system-bus code written to channels 0 or 1 is refused unchanged.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sel_reg[0] <= `OEC_SEL_RST;
      sel_reg[1] <= `OEC_SEL_RST;
      sel_reg[2] <= `OEC_SEL_RST;
      sel_reg[3] <= `OEC_SEL_RST;
      ctrl_reg   <= `OEC_CTRL_RST;
    end else begin
      ctrl_reg[`OEC_CTRL_CLR] <= 1'b0;
      if (commit && pwrite && !pslverr_reg) begin
        if (wr_sel) begin
          sel_reg[ch_idx] <= pwdata[3:0];
        end else if (idx == `OEC_IDX_CTRL) begin
          ctrl_reg <= pwdata[1:0];
        end
      end
    end
  end

  // Sticky overflow flags, write one to clear; a new overflow wins.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stat_reg <= 4'h0;
    end else if (commit && pwrite && (idx == `OEC_IDX_STAT)) begin
      stat_reg <= (stat_reg & ~pwdata[3:0]) | ovf;
    end else begin
      stat_reg <= stat_reg | ovf;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ch
      oec_chan #(
        .CNT_W (CNT_W)
      ) u_chan (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .run       (ctrl_reg[`OEC_CTRL_RUN]),
        .clear     (ctrl_reg[`OEC_CTRL_CLR]),
        .sel       (sel_reg[g]),
        .load      (commit & pwrite & wr_cnt & (ch_idx == g)),
        .load_data (pwdata[CNT_W-1:0]),
        .evt_inc   (evt_inc),
        .count     (cnt[g]),
        .ovf       (ovf[g])
      );
    end
  endgenerate

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
endmodule

// *** verification/oec_monitor.sv ***
// Checker of the APB answer of oec_top.
// Assumes a bind to oec_top; it sees the APB ports only.
`timescale 1ns/100ps
module oec_monitor (
  // Clock, reset and APB.
  input wire        clk_sys,
  input wire        reset_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // A taken access, and the two kinds that must be refused.
  sequence s_take;
    psel && penable && !pready;
  endsequence
  sequence s_bad_idx;
    s_take ##0 paddr[5:2] > 4'h9;
  endsequence
  sequence s_bad_sel;
    s_take ##0 pwrite && paddr[5:3] == 3'h0 && pwdata[3:2] == 2'h3;
  endsequence
  a_one_wait: assert property (s_take |=> pready)
    else $error("no answer after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than a cycle");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_zero: assert property (!pready || pwrite |-> prdata == 32'h0)
    else $error("prdata set outside a read answer");
  a_bad_index: assert property (s_bad_idx |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_sb_refuse: assert property (s_bad_sel |=> pslverr)
    else $error("bus code taken on a low channel");
  a_sel_taken: assert property (s_take ##0 pwrite && paddr[5:3] == 3'h0
    && pwdata[3:2] != 2'h3 |=> !pslverr)
    else $error("valid select refused");
endmodule

bind oec_top oec_monitor i_oec_monitor (
  .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr)
);

// *** verification/oec_sb_model.sv ***
// System bus model: bus clock and random cells, requests and grants.
// Assumes clk_sys from the bench; the bus clock is clk_sys / 8.
`timescale 1ns/100ps
module oec_sb_model (
  // Clock and burst enable.
  input  wire        clk_sys,
  input  wire        go,
  // Bus clock and lines: cells, req, gnt, r_req, r_gnt.
  output reg         sb_clk = 1'b0,
  output reg  [17:0] sb_bus = 18'h0
);
  reg [2:0] ph_reg = 3'h0;

  // The clock stands low between bursts; lines move on its falling edge,
  // so they are steady for four clk_sys cycles on either side of each rise.
  always @(posedge clk_sys) begin
    if (go || ph_reg != 3'h0) begin
      ph_reg <= ph_reg + 3'h1;
      sb_clk <= ph_reg >= 3'h3 && ph_reg != 3'h7;
      if (ph_reg == 3'h7) begin
        sb_bus <= 18'($urandom);
      end
    end
  end
endmodule

// *** verification/tb.sv ***
// Bench of oec_top: register access, CPU-side and system bus events.
// Assumes oec_sb_model on the bus side and the bound checker.
`timescale 1ns/100ps
module tb;
  reg         clk_sys = 1'b0;
  reg         reset_n = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg         act = 1'b0;
  reg         acc = 1'b0;
  reg         go = 1'b0;
  reg         r_err;
  reg  [3:0]  code = 4'h0;
  reg  [7:0]  paddr = 8'h00;
  reg  [18:0] v = 19'h0;
  reg  [31:0] pwdata = 32'h0;
  reg  [31:0] r_data, exp_cnt, d;
  reg  [31:0] exp_sb [0:3];
  integer     n_fail, samples_checked, k;
  wire [31:0] prdata;
  wire        pready, pslverr, sb_clk;
  wire [17:0] sb_bus;

  oec_top #(.CNT_W(32), .NREQ(4)) i_oec_top (
    .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xy_x_valid(v[0]), .xy_x_write(v[1]),
    .xy_y_valid(v[2]), .xy_y_write(v[3]), .op_rd_valid(v[4]), .op_wr_valid(v[5]),
    .op_lram_hit(v[6]), .op_ilm_hit(v[7]), .op_prefetch(v[8]), .oc_rd_miss(v[9]),
    .oc_wr_miss(v[10]), .oc_wr_through(v[11]), .op_rd_wait(v[12]),
    .op_wr_wait(v[13]), .rd_miss_wait(v[14]), .fill_wait(v[15]),
    .wr_miss_wait(v[16]), .ilm_rd_wait(v[17]), .ilm_wr_wait(v[18]),
    .sb_clk(sb_clk), .sb_req_cell(sb_bus[17]), .sb_rsp_cell(sb_bus[16]),
    .sb_req(sb_bus[15:12]), .sb_gnt(sb_bus[11:8]), .sb_r_req(sb_bus[7:4]),
    .sb_r_gnt(sb_bus[3:0])
  );
  oec_sb_model i_oec_sb_model (.clk_sys(clk_sys), .go(go), .sb_clk(sb_clk), .sb_bus(sb_bus));

  // A 25 ns clock period.
  always #12.5 clk_sys = ~clk_sys;

  // Expected increment of one clk_sys cycle for a CPU-side event code.
  function [1:0] ev_inc(input [3:0] c, input [18:0] e);
    reg b, r, w;
    begin
      b = e[0] & e[2];
      r = b | e[0] & ~e[1] | e[2] & ~e[3];
      w = b | e[0] & e[1] | e[2] & e[3];
      case (c)
        4'h1: ev_inc = r + (e[4] & e[6]);
        4'h2: ev_inc = w + (e[5] & e[6]);
        4'h3: ev_inc = (e[4] | e[5]) & e[7];
        4'h4: ev_inc = e[9] & ~e[8];
        4'h5: ev_inc = e[10] & ~e[11] & ~e[8];
        4'h6: ev_inc = e[12];
        4'h7: ev_inc = e[13];
        4'h8: ev_inc = e[14] | e[15];
        4'h9: ev_inc = e[16];
        4'ha: ev_inc = e[17];
        4'hb: ev_inc = e[18];
        default: ev_inc = 2'h0;
      endcase
    end
  endfunction

  // Random traffic; an operand read and write never share a cycle, nor two targets.
  function [18:0] rnd(input [31:0] u);
    begin
      rnd = u[18:0];
      rnd[5] = u[5] & ~u[4];
      rnd[7] = u[7] & ~u[6];
    end
  endfunction

  // CPU traffic while act is up; expectations summed while acc is up.
  always @(posedge clk_sys) begin
    if (acc) exp_cnt <= exp_cnt + ev_inc(code, v);
    v <= act ? rnd($urandom) : 19'h0;
  end

  // Several waits in one bus cycle are worth one count.
  always @(posedge sb_clk) begin
    if (acc) begin
      exp_sb[0] <= exp_sb[0] + sb_bus[17];
      exp_sb[1] <= exp_sb[1] + sb_bus[16];
      exp_sb[2] <= exp_sb[2] + |(sb_bus[15:12] & ~sb_bus[11:8]);
      exp_sb[3] <= exp_sb[3] + |(sb_bus[7:4] & ~sb_bus[3:0]);
    end
  end

  // Compares a seen value with the expected one and counts both.
  task check(input [32:0] seen, input [32:0] want);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== want) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t: seen %h, want %h", $time, seen, want);
      end
    end
  endtask

  task give_verdict;
    begin
      $display("checks %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  // One APB transfer, held until pready is seen at a rising edge.
  task apb(input w, input [3:0] idx, input [31:0] wd);
    integer i;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      i = 0;
      @(posedge clk_sys);
      while (pready !== 1'b1 && i < 20) begin
        @(posedge clk_sys);
        i = i + 1;
      end
      if (pready !== 1'b1) begin
        n_fail = n_fail + 1;
        give_verdict;
      end else begin
        r_data = prdata;
        r_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
      end
    end
  endtask

  // Clears and starts the counters; the expectations restart with them.
  task restart;
    integer j;
    begin
      apb(1'b1, 4'h8, 32'h2);
      apb(1'b1, 4'h8, 32'h1);
      exp_cnt <= 32'h0;
      for (j = 0; j < 4; j = j + 1) exp_sb[j] <= 32'h0;
      acc <= 1'b1;
    end
  endtask

  // Lets late bus counts land before run is turned off.
  task stop;
    begin
      repeat (16) @(posedge clk_sys);
      apb(1'b1, 4'h8, 32'h0);
      acc <= 1'b0;
    end
  endtask

  initial begin
    n_fail = 0;
    samples_checked = 0;
    d = $urandom(47958);
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    // Reset contents of the ten words, then an unmapped index.
    for (k = 0; k < 11; k = k + 1) begin
      apb(1'b0, k == 10 ? 4'hb : k[3:0], 32'h0);
      check({r_err, r_data}, {k == 10, 32'h0});
    end
    d = $urandom;
    apb(1'b1, 4'h5, d);
    apb(1'b0, 4'h5, 32'h0);
    check({r_err, r_data}, {1'b0, d});
    // Bus codes are refused on channels 0 and 1, taken on 2 and 3.
    for (k = 12; k < 16; k = k + 1) begin
      apb(1'b1, {3'h0, k[0]}, k);
      check({r_err, r_data}, {1'b1, 32'h0});
      apb(1'b0, {3'h0, k[0]}, 32'h0);
      check({r_err, r_data}, 33'h0);
      apb(1'b1, {3'h1, k[0]}, k);
      apb(1'b0, {3'h1, k[0]}, 32'h0);
      check({r_err, r_data}, {1'b0, k[31:0]});
    end
    // Each CPU-side code on channel 0, then traffic with run off.
    for (k = 1; k < 12; k = k + 1) begin
      code <= k[3:0];
      apb(1'b1, 4'h0, k);
      restart;
      act <= 1'b1;
      repeat (40) @(posedge clk_sys);
      act <= 1'b0;
      stop;
      act <= 1'b1;
      repeat (8) @(posedge clk_sys);
      act <= 1'b0;
      repeat (2) @(posedge clk_sys);
      apb(1'b0, 4'h4, 32'h0);
      check({r_err, r_data}, {1'b0, exp_cnt});
    end
    // Bus codes on channels 2 and 3 over twenty bus cycles.
    for (k = 0; k < 2; k = k + 1) begin
      apb(1'b1, 4'h2, 12 + k);
      apb(1'b1, 4'h3, 14 + k);
      restart;
      go <= 1'b1;
      repeat (160) @(posedge clk_sys);
      go <= 1'b0;
      stop;
      apb(1'b0, 4'h6, 32'h0);
      check({r_err, r_data}, {1'b0, exp_sb[k]});
      apb(1'b0, 4'h7, 32'h0);
      check({r_err, r_data}, {1'b0, exp_sb[k + 2]});
    end
    give_verdict;
  end
endmodule
